// *** hdl/bpt_thresholds.sv ***
`timescale 1ns/10ps
`default_nettype none
module bpt_thresholds #(
	parameter int SC_COUNT_WIDTH = 10,
	parameter int OC_COUNT_WIDTH = 14
) (
	// Clock and reset
	input  wire logic                                clk,
	input  wire logic                                rst_n,
	// Register port
	input  wire logic [bpt_pkg::ADDR_WIDTH-1:0]      regAddr,
	input  wire logic                                regWrite,
	input  wire logic                                regRead,
	input  wire logic [bpt_pkg::DATA_WIDTH-1:0]      regWrData,
	output logic [bpt_pkg::DATA_WIDTH-1:0]           regRdData,
	// Nonvolatile copies
	input  wire logic [bpt_pkg::DATA_WIDTH-1:0]      nvCurrentThresholds,
	input  wire logic [bpt_pkg::DATA_WIDTH-1:0]      nvCurrentDelays,
	input  wire logic                                comparatorRestoreEnable,
	// Measurements
	input  wire logic [15:0]                         cellVoltage,
	input  wire logic [15:0]                         filteredOpenCircuitVoltage,
	input  wire logic [15:0]                         temperature,
	input  wire logic [7:0]                          roomChargeCurrent,
	// Temperature limits, whole degrees, signed
	input  wire logic [7:0]                          tooColdLimit,
	input  wire logic [7:0]                          coldLimit,
	input  wire logic [7:0]                          warmLimit,
	input  wire logic [7:0]                          hotLimit,
	input  wire logic [7:0]                          tooHotLimit,
	// Comparator pins
	input  wire logic                                shortCircuitTrip,
	input  wire logic                                overdischargeTrip,
	input  wire logic                                overchargeTrip,
	// Protection outputs
	output logic                                     dischargeSwitchOpen,
	output logic                                     chargeSwitchOpen,
	output logic                                     shutdownRequest,
	output logic                                     overvoltageFault,
	output logic                                     permanentFailure,
	output logic                                     chargeBlocked,
	output logic                                     shortCircuitAlert,
	output logic                                     overdischargeAlert,
	output logic                                     overchargeAlert,
	// Derived levels
	output logic [bpt_pkg::LEVEL_WIDTH-1:0]          chargeVoltage,
	output logic [bpt_pkg::LEVEL_WIDTH-1:0]          overvoltageTripLevel,
	output logic [bpt_pkg::LEVEL_WIDTH-1:0]          overvoltageReleaseLevel,
	output logic [7:0]                               prechargeCurrent,
	output logic signed [bpt_pkg::CMP_WIDTH-1:0]     shortCircuitLevel,
	output logic signed [bpt_pkg::CMP_WIDTH-1:0]     overdischargeLevel,
	output logic signed [bpt_pkg::CMP_WIDTH-1:0]     overchargeLevel
);
	typedef struct packed {
		logic [15:0]                     uvReg;
		logic [15:0]                     uvBackup;
		logic [15:0]                     pfReg;
		logic [15:0]                     cvReg;
		logic [15:0]                     poReg;
		logic [15:0]                     ctReg;
		logic [15:0]                     cdReg;
		logic                            restoreDone;
		logic [bpt_pkg::TICK_WIDTH-1:0]  tickCount;
		logic                            tick;
		logic [1:0]                      scSync;
		logic [1:0]                      odSync;
		logic [1:0]                      ocSync;
		logic [15:0]                     rdData;
		logic                            dischargeOpen;
		logic                            chargeOpen;
		logic                            shutdown;
		logic                            ovFault;
		logic                            permFail;
		logic                            blocked;
		logic [bpt_pkg::LEVEL_WIDTH-1:0] charge;
		logic [bpt_pkg::LEVEL_WIDTH-1:0] ovTrip;
		logic [bpt_pkg::LEVEL_WIDTH-1:0] ovRelease;
		logic [7:0]                      precharge;
		logic [bpt_pkg::CMP_WIDTH-1:0]   scLevel;
		logic [bpt_pkg::CMP_WIDTH-1:0]   odLevel;
		logic [bpt_pkg::CMP_WIDTH-1:0]   ocLevel;
		logic [SC_COUNT_WIDTH-1:0]       scTarget;
		logic [OC_COUNT_WIDTH-1:0]       ocTarget;
	} bpt_thresholds_state_type;

	bpt_thresholds_state_type state;
	bpt_thresholds_state_type next_state;

	logic scDetected;
	logic odDetected;
	logic ocDetected;

	if (SC_COUNT_WIDTH < $clog2(bpt_pkg::SC_DELAY_MAX_US + 1) ||
			OC_COUNT_WIDTH < $clog2(bpt_pkg::OC_DELAY_MAX_US + 1) ||
			bpt_pkg::TICK_CYCLES > (1 << bpt_pkg::TICK_WIDTH)) begin : gCheck
		$error("bpt_thresholds: counter widths too small");
	end

	// Scale a 5mV level to cell register units
	function automatic logic [16:0] toCellScale(input int units);
		toCellScale = 17'(units * bpt_pkg::CELL_VOLTAGE_PER_UNIT);
	endfunction

	always_comb begin
		int          uvpI;
		int          ocvI;
		int          shdnI;
		int          roomI;
		int          warmI;
		int          coldI;
		int          hotI;
		int          chargeI;
		int          tripI;
		int          releaseI;
		int          preDiv;
		logic [16:0] cellFine;
		logic [16:0] ocvFine;
		logic signed [7:0] tempDeg;
		logic        uvTrip;
		logic        ocvTrip;
		uvpI = 0;
		ocvI = 0;
		shdnI = 0;
		roomI = 0;
		warmI = 0;
		coldI = 0;
		hotI = 0;
		chargeI = 0;
		tripI = 0;
		releaseI = 0;
		preDiv = 0;
		cellFine = {1'b0, cellVoltage};
		ocvFine = {1'b0, filteredOpenCircuitVoltage};
		tempDeg = $signed(temperature[bpt_pkg::TEMP_MSB:bpt_pkg::TEMP_LSB]);
		uvTrip = 1'b0;
		ocvTrip = 1'b0;
		next_state = state;

		// Microsecond timebase
		if (32'(state.tickCount) == bpt_pkg::TICK_CYCLES - 1) begin
			next_state.tickCount = '0;
			next_state.tick = 1'b1;
		end else begin
			next_state.tickCount = state.tickCount + 1'b1;
			next_state.tick = 1'b0;
		end

		// Pin synchronisers
		next_state.scSync = {state.scSync[0], shortCircuitTrip};
		next_state.odSync = {state.odSync[0], overdischargeTrip};
		next_state.ocSync = {state.ocSync[0], overchargeTrip};

		// Restore after reset
		if (!state.restoreDone) begin
			next_state.restoreDone = 1'b1;
			if (comparatorRestoreEnable) begin //[RQ19]
				next_state.ctReg = nvCurrentThresholds & bpt_pkg::MASK_CT; //[RQ19]
				next_state.cdReg = (nvCurrentDelays & bpt_pkg::MASK_CD) | bpt_pkg::FORCED_CD;
			end
		end

		// Register writes
		if (regWrite) begin
			unique case (regAddr)
				bpt_pkg::ADDR_UV:        next_state.uvReg = regWrData; //[RQ20]
				bpt_pkg::ADDR_UV_BACKUP: next_state.uvBackup = regWrData;
				bpt_pkg::ADDR_PF:        next_state.pfReg = regWrData & bpt_pkg::MASK_PF;
				bpt_pkg::ADDR_CV:        next_state.cvReg = regWrData;
				bpt_pkg::ADDR_PO:        next_state.poReg = regWrData;
				bpt_pkg::ADDR_CT:        next_state.ctReg = regWrData & bpt_pkg::MASK_CT;
				bpt_pkg::ADDR_CD: begin
					next_state.cdReg = (regWrData & bpt_pkg::MASK_CD) | bpt_pkg::FORCED_CD;
				end
				default: begin
				end
			endcase
		end

		// Register reads
		if (regRead) begin
			unique case (regAddr)
				bpt_pkg::ADDR_UV:        next_state.rdData = state.uvReg;
				bpt_pkg::ADDR_UV_BACKUP: next_state.rdData = state.uvBackup;
				bpt_pkg::ADDR_PF:        next_state.rdData = state.pfReg;
				bpt_pkg::ADDR_CV:        next_state.rdData = state.cvReg;
				bpt_pkg::ADDR_PO:        next_state.rdData = state.poReg;
				bpt_pkg::ADDR_CT:        next_state.rdData = state.ctReg;
				bpt_pkg::ADDR_CD:        next_state.rdData = state.cdReg;
				default:                 next_state.rdData = bpt_pkg::READ_UNMAPPED;
			endcase
		end

		// Undervoltage, open-circuit and shutdown levels
		uvpI = bpt_pkg::UVP_BASE_U
			+ bpt_pkg::UVP_STEP_U * int'(state.uvReg[bpt_pkg::UVP_MSB:bpt_pkg::UVP_LSB]); //[RQ1]
		ocvI = uvpI
			+ bpt_pkg::UOCV_STEP_U * int'(state.uvReg[bpt_pkg::UOCV_MSB:bpt_pkg::UOCV_LSB]); //[RQ3]
		shdnI = uvpI + bpt_pkg::SHDN_STEP_U
			* int'($signed(state.uvReg[bpt_pkg::SHDN_MSB:bpt_pkg::SHDN_LSB])); //[RQ4]
		if (shdnI > uvpI) begin
			shdnI = uvpI; //[RQ5]
		end
		uvTrip = cellFine < toCellScale(uvpI) && !state.uvReg[bpt_pkg::UVDIS_BIT]; //[RQ1] [RQ2]
		ocvTrip = ocvFine < toCellScale(ocvI); //[RQ3]
		next_state.shutdown = cellFine < toCellScale(shdnI); //[RQ4] [RQ5]

		// Permanent failure latches until reset
		if (cellFine > {1'b0, state.pfReg[bpt_pkg::PF_MSB:bpt_pkg::PF_LSB], 8'h00}) begin
			next_state.permFail = 1'b1; //[RQ6]
		end

		// Temperature-zone charge voltage
		roomI = bpt_pkg::ROOM_BASE_U + bpt_pkg::ROOM_STEP_U
			* int'($signed(state.cvReg[bpt_pkg::ROOM_MSB:bpt_pkg::ROOM_LSB])); //[RQ7]
		coldI = roomI - bpt_pkg::DELTA_STEP_U
			* int'(state.cvReg[bpt_pkg::COLD_MSB:bpt_pkg::COLD_LSB]); //[RQ8]
		warmI = roomI - bpt_pkg::DELTA_STEP_U
			* int'(state.cvReg[bpt_pkg::WARM_MSB:bpt_pkg::WARM_LSB]); //[RQ9]
		hotI = warmI - bpt_pkg::DELTA_STEP_U
			* int'(state.cvReg[bpt_pkg::HOT_MSB:bpt_pkg::HOT_LSB]); //[RQ10]
		next_state.blocked = 1'b0;
		if (tempDeg < $signed(tooColdLimit)) begin //[RQ24]
			chargeI = coldI;
			next_state.blocked = 1'b1;
		end else if (tempDeg < $signed(coldLimit)) begin
			chargeI = coldI; //[RQ8]
		end else if (tempDeg > $signed(tooHotLimit)) begin
			chargeI = hotI;
			next_state.blocked = 1'b1;
		end else if (tempDeg > $signed(hotLimit)) begin
			chargeI = hotI; //[RQ10]
		end else if (tempDeg > $signed(warmLimit)) begin
			chargeI = warmI; //[RQ9]
		end else begin
			chargeI = roomI; //[RQ11]
		end
		next_state.charge = bpt_pkg::LEVEL_WIDTH'(chargeI); //[RQ12]

		// Overvoltage trip and release with hysteresis
		tripI = chargeI + bpt_pkg::OV_STEP_U
			* int'(state.poReg[bpt_pkg::OVP_MSB:bpt_pkg::OVP_LSB]); //[RQ12] [RQ14]
		releaseI = tripI - bpt_pkg::OV_STEP_U
			* int'(state.poReg[bpt_pkg::OVERVOLTAGE_RELEASE_LEVEL_MSB:bpt_pkg::OVERVOLTAGE_RELEASE_LEVEL_LSB]); //[RQ15]
		next_state.ovTrip = bpt_pkg::LEVEL_WIDTH'(tripI);
		next_state.ovRelease = bpt_pkg::LEVEL_WIDTH'(releaseI);
		if (cellFine > toCellScale(tripI)) begin
			next_state.ovFault = 1'b1; //[RQ14]
		end else if (cellFine < toCellScale(releaseI)) begin
			next_state.ovFault = 1'b0; //[RQ23]
		end

		// Precharge current, zero field gives zero
		preDiv = 2 * int'(state.poReg[bpt_pkg::PRE_MSB:bpt_pkg::PRE_LSB]);
		if (preDiv == 0) begin
			next_state.precharge = '0;
		end else begin
			next_state.precharge = 8'(int'(roomChargeCurrent) / preDiv); //[RQ13]
		end

		// Current comparator levels
		next_state.scLevel = bpt_pkg::CMP_WIDTH'(bpt_pkg::SC_BASE_U + bpt_pkg::SC_STEP_U
			* int'(state.ctReg[bpt_pkg::SHORT_CIRCUIT_LEVEL_MSB:bpt_pkg::SHORT_CIRCUIT_LEVEL_LSB])); //[RQ16]
		next_state.odLevel = bpt_pkg::CMP_WIDTH'(bpt_pkg::OD_BASE_U + bpt_pkg::OD_STEP_U
			* int'(state.ctReg[bpt_pkg::OVERDISCHARGE_LEVEL_MSB:bpt_pkg::OVERDISCHARGE_LEVEL_LSB])); //[RQ17]
		next_state.ocLevel = bpt_pkg::CMP_WIDTH'(bpt_pkg::OC_BASE_U - bpt_pkg::OC_STEP_U
			* int'(state.ctReg[bpt_pkg::OVERCHARGE_LEVEL_MSB:bpt_pkg::OVERCHARGE_LEVEL_LSB])); //[RQ18]

		// Debounce targets in microsecond ticks
		next_state.scTarget = SC_COUNT_WIDTH'(bpt_pkg::SC_BASE_US + bpt_pkg::SC_STEP_US
			* int'(state.cdReg[bpt_pkg::SHORT_CIRCUIT_DEBOUNCE_MSB:bpt_pkg::SHORT_CIRCUIT_DEBOUNCE_LSB])); //[RQ21]
		next_state.ocTarget = OC_COUNT_WIDTH'(bpt_pkg::OC_BASE_US + bpt_pkg::OC_STEP_US
			* int'(state.cdReg[bpt_pkg::OVERCURRENT_DEBOUNCE_MSB:bpt_pkg::OVERCURRENT_DEBOUNCE_LSB])); //[RQ22]

		// Switch control
		next_state.dischargeOpen = uvTrip | ocvTrip | scDetected | odDetected; //[RQ1] [RQ3]
		next_state.chargeOpen = next_state.blocked | state.ovFault | state.permFail
			| ocDetected;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
			state.uvReg <= bpt_pkg::RESET_UV;
			state.uvBackup <= bpt_pkg::RESET_UV;
			state.pfReg <= bpt_pkg::RESET_PF;
			state.cvReg <= bpt_pkg::RESET_CV;
			state.poReg <= bpt_pkg::RESET_PO;
			state.ctReg <= bpt_pkg::RESET_CT;
			state.cdReg <= bpt_pkg::RESET_CD;
		end else begin
			state <= next_state;
		end
	end

	bpt_debounce #(
		.COUNT_WIDTH (SC_COUNT_WIDTH)
	) uShortCircuit (
		.clk      (clk),
		.rst_n    (rst_n),
		.tick     (state.tick),
		.level    (state.scSync[1]),
		.target   (state.scTarget),
		.detected (scDetected)
	); //[RQ21]

	bpt_debounce #(
		.COUNT_WIDTH (OC_COUNT_WIDTH)
	) uOverdischarge (
		.clk      (clk),
		.rst_n    (rst_n),
		.tick     (state.tick),
		.level    (state.odSync[1]),
		.target   (state.ocTarget),
		.detected (odDetected)
	); //[RQ22]

	bpt_debounce #(
		.COUNT_WIDTH (OC_COUNT_WIDTH)
	) uOvercharge (
		.clk      (clk),
		.rst_n    (rst_n),
		.tick     (state.tick),
		.level    (state.ocSync[1]),
		.target   (state.ocTarget),
		.detected (ocDetected)
	); //[RQ22]

	assign regRdData               = state.rdData;
	assign dischargeSwitchOpen     = state.dischargeOpen;
	assign chargeSwitchOpen        = state.chargeOpen;
	assign shutdownRequest         = state.shutdown;
	assign overvoltageFault        = state.ovFault;
	assign permanentFailure        = state.permFail;
	assign chargeBlocked           = state.blocked;
	assign shortCircuitAlert       = scDetected;
	assign overdischargeAlert      = odDetected;
	assign overchargeAlert         = ocDetected;
	assign chargeVoltage           = state.charge;
	assign overvoltageTripLevel    = state.ovTrip;
	assign overvoltageReleaseLevel = state.ovRelease;
	assign prechargeCurrent        = state.precharge;
	assign shortCircuitLevel       = state.scLevel;
	assign overdischargeLevel      = state.odLevel;
	assign overchargeLevel         = state.ocLevel;
endmodule
`default_nettype wire

// *** hdl/bpt_pkg.sv ***
// How it works
// [RQ1] Undervoltage below level opens discharge switch
// [RQ2] Disable bit suppresses only undervoltage protection
// [RQ3] Open-circuit voltage below level plus offset protects
// [RQ4] Shutdown level is level plus signed offset
// [RQ5] Shutdown never above undervoltage protect level
// [RQ6] Cell above permanent-failure field latches failure
// [RQ7] Room charge voltage is signed offset from 4.2V
// [RQ8] Cold zone subtracts cold delta from room
// [RQ9] Warm zone subtracts warm delta from room
// [RQ10] Hot zone subtracts hot delta from warm
// [RQ11] Zero deltas give one flat charge voltage
// [RQ12] Charge voltage reported and feeds overvoltage level
// [RQ13] Precharge is room current over twice field
// [RQ14] Overvoltage trip is charge plus offset
// [RQ15] Overvoltage release is trip minus offset
// [RQ16] Short-circuit level is -155mV plus 5mV steps
// [RQ17] Overdischarge level is -77.5mV plus 2.5mV steps
// [RQ18] Overcharge level is 38.75mV minus 1.25mV steps
// [RQ19] Comparator registers restored only when enabled
// [RQ20] Host writes backup copy before undervoltage register
// [RQ21] Short-circuit debounce 70us plus 61us steps
// [RQ22] Current debounce 70us plus 977us steps
// [RQ23] Overvoltage fault holds until below release
// [RQ24] Charge voltage follows measured temperature zone
package bpt_pkg;
	// Register map
	localparam int          ADDR_WIDTH     = 9;
	localparam int          DATA_WIDTH     = 16;
	localparam logic [8:0]  ADDR_UV        = 9'h1d0;
	localparam logic [8:0]  ADDR_UV_BACKUP = 9'h0d6;
	localparam logic [8:0]  ADDR_PF        = 9'h1d4;
	localparam logic [8:0]  ADDR_CV        = 9'h1d9;
	localparam logic [8:0]  ADDR_PO        = 9'h1da;
	localparam logic [8:0]  ADDR_CT        = 9'h1dd;
	localparam logic [8:0]  ADDR_CD        = 9'h1de;
	// Reset values and masks
	localparam logic [15:0] RESET_UV       = 16'h0000;
	localparam logic [15:0] RESET_PF       = 16'hff00;
	localparam logic [15:0] RESET_CV       = 16'h0000;
	localparam logic [15:0] RESET_PO       = 16'h0000;
	localparam logic [15:0] RESET_CT       = 16'h0000;
	localparam logic [15:0] RESET_CD       = 16'h4050;
	localparam logic [15:0] MASK_PF        = 16'hff00;
	localparam logic [15:0] MASK_CT        = 16'h7fff;
	localparam logic [15:0] MASK_CD        = 16'h0f0f;
	localparam logic [15:0] FORCED_CD      = 16'h4050;
	localparam logic [15:0] READ_UNMAPPED  = 16'h0000;
	// Field positions
	localparam int UVP_MSB    = 15;
	localparam int UVP_LSB    = 10;
	localparam int UVDIS_BIT  = 9;
	localparam int UOCV_MSB   = 8;
	localparam int UOCV_LSB   = 4;
	localparam int SHDN_MSB   = 3;
	localparam int SHDN_LSB   = 0;
	localparam int PF_MSB     = 15;
	localparam int PF_LSB     = 8;
	localparam int ROOM_MSB   = 15;
	localparam int ROOM_LSB   = 8;
	localparam int WARM_MSB   = 7;
	localparam int WARM_LSB   = 6;
	localparam int COLD_MSB   = 5;
	localparam int COLD_LSB   = 3;
	localparam int HOT_MSB    = 2;
	localparam int HOT_LSB    = 0;
	localparam int PRE_MSB    = 15;
	localparam int PRE_LSB    = 8;
	localparam int OVP_MSB    = 7;
	localparam int OVP_LSB    = 4;
	localparam int OVERVOLTAGE_RELEASE_LEVEL_MSB   = 3;
	localparam int OVERVOLTAGE_RELEASE_LEVEL_LSB   = 0;
	localparam int OVERCHARGE_LEVEL_MSB   = 14;
	localparam int OVERCHARGE_LEVEL_LSB   = 10;
	localparam int SHORT_CIRCUIT_LEVEL_MSB   = 9;
	localparam int SHORT_CIRCUIT_LEVEL_LSB   = 5;
	localparam int OVERDISCHARGE_LEVEL_MSB   = 4;
	localparam int OVERDISCHARGE_LEVEL_LSB   = 0;
	localparam int SHORT_CIRCUIT_DEBOUNCE_MSB  = 11;
	localparam int SHORT_CIRCUIT_DEBOUNCE_LSB  = 8;
	localparam int OVERCURRENT_DEBOUNCE_MSB  = 3;
	localparam int OVERCURRENT_DEBOUNCE_LSB  = 0;
	localparam int TEMP_MSB   = 15;
	localparam int TEMP_LSB   = 8;
	// Voltage levels, held in 5mV units
	localparam int UNIT_MV         = 5;
	localparam int CELL_VOLTAGE_PER_UNIT  = 64;
	localparam int LEVEL_WIDTH     = 11;
	localparam int UVP_BASE_MV     = 2200;
	localparam int UVP_STEP_MV     = 20;
	localparam int UOCV_STEP_MV    = 40;
	localparam int SHDN_STEP_MV    = 40;
	localparam int ROOM_BASE_MV    = 4200;
	localparam int ROOM_STEP_MV    = 5;
	localparam int DELTA_STEP_MV   = 20;
	localparam int OV_STEP_MV      = 10;
	localparam int UVP_BASE_U      = UVP_BASE_MV / UNIT_MV;
	localparam int UVP_STEP_U      = UVP_STEP_MV / UNIT_MV;
	localparam int UOCV_STEP_U     = UOCV_STEP_MV / UNIT_MV;
	localparam int SHDN_STEP_U     = SHDN_STEP_MV / UNIT_MV;
	localparam int ROOM_BASE_U     = ROOM_BASE_MV / UNIT_MV;
	localparam int ROOM_STEP_U     = ROOM_STEP_MV / UNIT_MV;
	localparam int DELTA_STEP_U    = DELTA_STEP_MV / UNIT_MV;
	localparam int OV_STEP_U       = OV_STEP_MV / UNIT_MV;
	// Comparator levels, held in 1.25mV units
	localparam int CMP_UNIT_UV     = 1250;
	localparam int CMP_WIDTH       = 9;
	localparam int SC_BASE_UV      = -155000;
	localparam int SC_STEP_UV      = 5000;
	localparam int OD_BASE_UV      = -77500;
	localparam int OD_STEP_UV      = 2500;
	localparam int OC_BASE_UV      = 38750;
	localparam int OC_STEP_UV      = 1250;
	localparam int SC_BASE_U       = SC_BASE_UV / CMP_UNIT_UV;
	localparam int SC_STEP_U       = SC_STEP_UV / CMP_UNIT_UV;
	localparam int OD_BASE_U       = OD_BASE_UV / CMP_UNIT_UV;
	localparam int OD_STEP_U       = OD_STEP_UV / CMP_UNIT_UV;
	localparam int OC_BASE_U       = OC_BASE_UV / CMP_UNIT_UV;
	localparam int OC_STEP_U       = OC_STEP_UV / CMP_UNIT_UV;
	// Timing
	localparam int CLK_PERIOD_NS   = 10;
	localparam int TICK_NS         = 1000;
	localparam int TICK_CYCLES     = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_WIDTH      = 7;
	localparam int SC_BASE_US      = 70;
	localparam int SC_STEP_US      = 61;
	localparam int SC_EXTRA_US     = 31;
	localparam int OC_BASE_US      = 70;
	localparam int OC_STEP_US      = 977;
	localparam int SC_DELAY_MAX_US = SC_BASE_US + SC_STEP_US * 15;
	localparam int OC_DELAY_MAX_US = OC_BASE_US + OC_STEP_US * 15;
endpackage

// *** hdl/bpt_debounce.sv ***
`timescale 1ns/10ps
`default_nettype none
module bpt_debounce #(
	parameter int COUNT_WIDTH = 14
) (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// Timebase and comparator level
	input  wire logic                   tick,
	input  wire logic                   level,
	input  wire logic [COUNT_WIDTH-1:0] target,
	// Debounced result
	output logic                        detected
);
	typedef struct packed {
		logic [COUNT_WIDTH-1:0] count;
		logic                   detected;
	} bpt_debounce_state_type;

	bpt_debounce_state_type state;
	bpt_debounce_state_type next_state;

	if (COUNT_WIDTH < 2) begin : gCheck
		$error("bpt_debounce: COUNT_WIDTH too small");
	end

	// Level must stay high for target+1 ticks; any drop restarts
	always_comb begin
		next_state = state;
		if (!level) begin
			next_state.count = '0;
			next_state.detected = 1'b0;
		end else if (tick) begin
			if (state.count >= target) begin
				next_state.detected = 1'b1;
			end else begin
				next_state.count = state.count + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign detected = state.detected;
endmodule
`default_nettype wire

// *** dv/bpt_thresholds_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module bpt_thresholds_properties (
	// Clock, reset, register port
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic [8:0]        regAddr,
	input wire logic              regWrite,
	input wire logic [15:0]       regWrData,
	// Measurement and results
	input wire logic [15:0]       cellVoltage,
	input wire logic              dischargeSwitchOpen,
	input wire logic              shutdownRequest,
	input wire logic              overvoltageFault,
	input wire logic [10:0]       chargeVoltage,
	input wire logic [10:0]       overvoltageTripLevel,
	input wire logic [10:0]       overvoltageReleaseLevel,
	input wire logic signed [8:0] shortCircuitLevel,
	input wire logic signed [8:0] overdischargeLevel,
	input wire logic signed [8:0] overchargeLevel
);
	logic [15:0] uv;
	int          uvLvl;
	int          sdLvl;
	wire         wCt = regWrite && regAddr == bpt_pkg::ADDR_CT;
	wire         wPo = regWrite && regAddr == bpt_pkg::ADDR_PO;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			uv <= bpt_pkg::RESET_UV;
		else if (regWrite && regAddr == bpt_pkg::ADDR_UV)
			uv <= regWrData;
	end
	always_comb begin
		uvLvl = 440 + 4 * int'(uv[15:10]);
		sdLvl = uvLvl + 8 * int'($signed(uv[3:0]));
		if (sdLvl > uvLvl)
			sdLvl = uvLvl;
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	property p_uv; !uv[9] && cellVoltage < uvLvl * 64 |=> dischargeSwitchOpen; endproperty
	a_uv: assert property (p_uv) else $error("uv open missing");
	property p_sd; cellVoltage < sdLvl * 64 |=> shutdownRequest; endproperty
	a_sd: assert property (p_sd) else $error("shutdown missing");
	property p_sc; logic [15:0] d; (wCt, d = regWrData) |-> ##2
		int'(shortCircuitLevel) == -124 + 4 * int'(d[9:5]); endproperty
	a_sc: assert property (p_sc) else $error("sc level");
	property p_od; logic [15:0] d; (wCt, d = regWrData) |-> ##2
		int'(overdischargeLevel) == -62 + 2 * int'(d[4:0]); endproperty
	a_od: assert property (p_od) else $error("od level");
	property p_oc; logic [15:0] d; (wCt, d = regWrData) |-> ##2
		int'(overchargeLevel) == 31 - int'(d[14:10]); endproperty
	a_oc: assert property (p_oc) else $error("oc level");
	property p_trip; logic [15:0] d; (wPo, d = regWrData) |-> ##2
		overvoltageTripLevel == chargeVoltage + 2 * d[7:4]; endproperty
	a_trip: assert property (p_trip) else $error("trip level");
	property p_rel; logic [15:0] d; (wPo, d = regWrData) |-> ##2
		overvoltageReleaseLevel == overvoltageTripLevel - 2 * d[3:0]; endproperty
	a_rel: assert property (p_rel) else $error("release level");
	property p_hold; $past(overvoltageFault) && !overvoltageFault
		|-> $past(cellVoltage) < 64 * overvoltageReleaseLevel; endproperty
	a_hold: assert property (p_hold) else $error("fault dropped");
	c_fault: cover property ($rose(overvoltageFault));
	c_shut: cover property ($rose(shutdownRequest));
	c_open: cover property ($rose(dischargeSwitchOpen));
endmodule
bind bpt_thresholds bpt_thresholds_properties chk_u (.*);
`default_nettype wire

// *** dv/bpt_thresholds_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin nChecks++; if ((a) !== (e)) begin miscompares++; \
	$display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module bpt_thresholds_tb;
	logic clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
	logic comparatorRestoreEnable = 1'b1;
	logic [8:0] regAddr = 9'h000;
	logic [15:0] regWrData = 16'h0000, nvCurrentThresholds = 16'hfc21, nvCurrentDelays = 16'h0a03;
	logic [15:0] cellVoltage = 16'hc800, filteredOpenCircuitVoltage = 16'hc800;
	logic [15:0] temperature = 16'h1900, regRdData;
	logic [7:0] roomChargeCurrent = 8'hf0, prechargeCurrent, tooColdLimit = 8'h00;
	logic [7:0] coldLimit = 8'h0a, warmLimit = 8'h28, hotLimit = 8'h2d, tooHotLimit = 8'h3c;
	logic dischargeSwitchOpen, shutdownRequest, overvoltageFault, permanentFailure;
	logic shortCircuitTrip = 1'b0, overdischargeTrip = 1'b0, overchargeTrip = 1'b0;
	logic chargeSwitchOpen, chargeBlocked, shortCircuitAlert, overdischargeAlert, overchargeAlert;
	logic [10:0] chargeVoltage, overvoltageTripLevel, overvoltageReleaseLevel;
	logic signed [8:0] shortCircuitLevel, overdischargeLevel, overchargeLevel;
	logic [4:0] fv [5] = '{5'h00, 5'h01, 5'h10, 5'h1e, 5'h1f};
	int nChecks = 0, miscompares = 0, cyc = 0;
	bpt_thresholds dut_u (.*);
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", nChecks, miscompares);
		if (miscompares == 0 && nChecks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			print_verdict();
		end
	end
	task automatic wr(input logic [8:0] a, input logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [8:0] a, input logic [15:0] e);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1;
		`CHK(regRdData, e)
	endtask
	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic drvCell(input logic [15:0] v);
		@(posedge clk);
		cellVoltage <= v;
		settle();
	endtask
	task automatic uvWr(input logic [15:0] v);
		wr(bpt_pkg::ADDR_UV_BACKUP, v);
		wr(bpt_pkg::ADDR_UV, v);
		settle();
	endtask
	task automatic checkRegs(input logic [15:0] ct, input logic [15:0] cd);
		rd(bpt_pkg::ADDR_UV, bpt_pkg::RESET_UV);
		rd(bpt_pkg::ADDR_PF, bpt_pkg::RESET_PF);
		rd(bpt_pkg::ADDR_CV, bpt_pkg::RESET_CV);
		rd(bpt_pkg::ADDR_CT, ct);
		rd(bpt_pkg::ADDR_CD, cd);
		rd(9'h100, bpt_pkg::READ_UNMAPPED);
	endtask
	task automatic cvCase(input logic [15:0] v, input logic [7:0] t, input int e);
		wr(bpt_pkg::ADDR_CV, v);
		@(posedge clk);
		temperature <= {t, 8'h00};
		settle();
		`CHK(chargeVoltage, e)
		`CHK(overvoltageTripLevel, e + 10)
		`CHK(overvoltageReleaseLevel, e + 2)
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		checkRegs(16'h7c21, 16'h4a53);
		@(posedge clk);
		rst_n <= 1'b0;
		comparatorRestoreEnable <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		checkRegs(bpt_pkg::RESET_CT, bpt_pkg::RESET_CD);
		for (int i = 0; i < 5; i++) begin
			wr(bpt_pkg::ADDR_CT, {1'b1, fv[i], fv[i], fv[i]});
			rd(bpt_pkg::ADDR_CT, {1'b0, fv[i], fv[i], fv[i]});
			settle();
			`CHK(int'(shortCircuitLevel), -124 + 4 * int'(fv[i]))
			`CHK(int'(overdischargeLevel), -62 + 2 * int'(fv[i]))
			`CHK(int'(overchargeLevel), 31 - int'(fv[i]))
		end
		wr(bpt_pkg::ADDR_PO, 16'h0354);
		cvCase(16'h14ff, 8'h19, 860);
		cvCase(16'h14ff, 8'h05, 832);
		cvCase(16'h14ff, 8'h2a, 848);
		cvCase(16'h14ff, 8'h32, 820);
		cvCase(16'h14ff, 8'hfb, 832);
		`CHK({chargeBlocked, chargeSwitchOpen}, 2'b11)
		cvCase(16'h8000, 8'h32, 712);
		cvCase(16'h7f00, 8'h05, 967);
		cvCase(16'h0000, 8'h19, 840);
		`CHK(prechargeCurrent, 8'h28)
		drvCell(16'hd4c0);
		`CHK(overvoltageFault, 1'b1)
		drvCell(16'hd2c0);
		`CHK(overvoltageFault, 1'b1)
		drvCell(16'hd240);
		`CHK(overvoltageFault, 1'b0)
		uvWr(16'h640e);
		drvCell(16'h86c0);
		`CHK({dischargeSwitchOpen, shutdownRequest}, 2'b10)
		drvCell(16'h82c0);
		`CHK(shutdownRequest, 1'b1)
		uvWr(16'h660e);
		`CHK({dischargeSwitchOpen, shutdownRequest}, 2'b01)
		uvWr(16'h6403);
		drvCell(16'h86c0);
		`CHK({dischargeSwitchOpen, shutdownRequest}, 2'b11)
		drvCell(16'h8700);
		`CHK({dischargeSwitchOpen, shutdownRequest}, 2'b00)
		uvWr(16'h6613);
		@(posedge clk);
		filteredOpenCircuitVoltage <= 16'h88c0;
		settle();
		`CHK(dischargeSwitchOpen, 1'b1)
		wr(bpt_pkg::ADDR_PF, 16'hc0ff);
		rd(bpt_pkg::ADDR_PF, 16'hc000);
		drvCell(16'hc000);
		`CHK(permanentFailure, 1'b0)
		drvCell(16'hc001);
		drvCell(16'h8700);
		`CHK(permanentFailure, 1'b1)
		@(posedge clk);
		shortCircuitTrip <= 1'b1;
		overdischargeTrip <= 1'b1;
		overchargeTrip <= 1'b1;
		repeat (6800) @(posedge clk);
		#1;
		`CHK({shortCircuitAlert, overdischargeAlert, overchargeAlert}, 3'b000)
		repeat (500) @(posedge clk);
		#1;
		`CHK({shortCircuitAlert, overdischargeAlert, overchargeAlert}, 3'b111)
		print_verdict();
	end
endmodule
`default_nettype wire
